// ===== pciir_pkg.sv
/*
  Constants shared by the PCI interrupt routing block: configuration byte
  offsets, field positions, reset values and the legal ISA target codes.
  Assumes a byte-wide configuration access port on the bridge core clock.
*/
`default_nettype none

package pciir_pkg;

  // ------------------------------------------------------------------
  // Configuration byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] PCIIR_SCI_IRQ_SELECT_OFS = 8'h44;
  localparam logic [7:0] PCIIR_PCI_INT_A_ROUTE_OFS = 8'h60;
  localparam logic [7:0] PCIIR_PCI_INT_B_ROUTE_OFS = 8'h61;
  localparam logic [7:0] PCIIR_PCI_INT_C_ROUTE_OFS = 8'h62;
  localparam logic [7:0] PCIIR_PCI_INT_D_ROUTE_OFS = 8'h63;
  localparam logic [7:0] PCIIR_PCI_INT_E_ROUTE_OFS = 8'h68;
  localparam logic [7:0] PCIIR_PCI_INT_F_ROUTE_OFS = 8'h69;
  localparam logic [7:0] PCIIR_PCI_INT_G_ROUTE_OFS = 8'h6A;
  localparam logic [7:0] PCIIR_PCI_INT_H_ROUTE_OFS = 8'h6B;
  localparam logic [7:0] PCIIR_ROUTE_OFS [8] = '{
    PCIIR_PCI_INT_A_ROUTE_OFS, PCIIR_PCI_INT_B_ROUTE_OFS,
    PCIIR_PCI_INT_C_ROUTE_OFS, PCIIR_PCI_INT_D_ROUTE_OFS,
    PCIIR_PCI_INT_E_ROUTE_OFS, PCIIR_PCI_INT_F_ROUTE_OFS,
    PCIIR_PCI_INT_G_ROUTE_OFS, PCIIR_PCI_INT_H_ROUTE_OFS
  };

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int PCIIR_ROUTE_DISABLE_BIT = 7;
  localparam logic [7:0] PCIIR_ROUTE_WR_MASK = 8'h8F;
  localparam logic [7:0] PCIIR_SCI_WR_MASK = 8'h07;
  localparam logic [15:0] PCIIR_ISA_VALID = 16'hDEF8;
  localparam int PCIIR_NUM_LINES = 8;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [2:0] PCIIR_SCI_SEL_RESET = 3'h0;
  localparam logic [7:0] PCIIR_ROUTE_RESET = 8'h80;

  // ------------------------------------------------------------------
  // SCI target codes
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    PCIIR_SCI_IRQ9 = 3'h0,
    PCIIR_SCI_IRQ10 = 3'h1,
    PCIIR_SCI_IRQ11 = 3'h2,
    PCIIR_SCI_RSVD = 3'h3,
    PCIIR_SCI_APIC20 = 3'h4,
    PCIIR_SCI_APIC21 = 3'h5,
    PCIIR_SCI_APIC22 = 3'h6,
    PCIIR_SCI_APIC23 = 3'h7
  } pciir_sci_sel_t;

endpackage

`default_nettype wire

// ===== pciir_line_decode.sv
/*
  Decoder for one PCI interrupt line: turns the line's routing byte and its
  active level into a one-hot vector over the sixteen ISA IRQ inputs.
  Assumes the line level is already synchronised to the core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pciir_line_decode
  import pciir_pkg::*;
(
  // Routing byte and line state
  input wire logic [7:0] route,
  input wire logic line_act,
  // ISA target vector
  output logic [15:0] irq_vec
);

  logic [15:0] onehot;

  always_comb begin
    onehot = 16'h0001 << route[3:0];
    irq_vec = 16'h0000;
    // Reserved codes fall outside the valid mask and drive nothing. see [R8]
    if (line_act && !route[PCIIR_ROUTE_DISABLE_BIT]) begin // see [R6] see [R7]
      irq_vec = onehot & PCIIR_ISA_VALID;
    end
  end

endmodule

`default_nettype wire

// ===== pciir_route.sv
/*
  PCI interrupt routing block: SCI select byte and eight routing bytes in
  configuration space, steering SCI and PCI interrupt lines A to H onto the
  ISA IRQ inputs of the 8259 pair or, for SCI, the APIC inputs 20 to 23.
  Assumes a byte-wide configuration port on ref_clk, PCI lines from pins
  (active low) and SCI and APIC enable from logic on the same clock.
*/
// Behaviour
// [R1] SCI defaults to IRQ9 after reset
// [R2] SCI select bits 2:0 at 0x44
// [R3] Codes 100-111 reach IRQ20-23 only with APIC
// [R4] Lines A-D routing bytes at 0x60-0x63
// [R5] Lines E-H routing bytes at 0x68-0x6B
// [R6] Bit7 clear routes line to coded ISA IRQ
// [R7] Bit7 set keeps line off the 8259
// [R8] Software avoids reserved target codes
// [R9] Routing bits 6:4 read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none

module pciir_route
  import pciir_pkg::*;
#(
  parameter int NUM_LINES = PCIIR_NUM_LINES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Configuration byte port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  // Interrupt sources
  input wire logic [NUM_LINES-1:0] pci_interrupt_line_n,
  input wire logic sci_in,
  input wire logic apic_enable,
  // Interrupt targets
  output logic [15:0] isa_irq,
  output logic [3:0] apic_irq
);

  // ------------------------------------------------------------------
  // Elaboration check
  // ------------------------------------------------------------------
  if (NUM_LINES != PCIIR_NUM_LINES) begin : g_bad_lines
    $error("pciir_route supports exactly eight PCI interrupt lines");
  end

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  logic [2:0] sci_sel_q;
  logic [2:0] sci_sel_d;
  logic [7:0] route_q [NUM_LINES];
  logic [7:0] route_d [NUM_LINES];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  always_comb begin
    sci_sel_d = sci_sel_q;
    rdata_d = rdata_q;
    for (int i = 0; i < NUM_LINES; i++) begin
      route_d[i] = route_q[i];
    end
    if (cfg_wr && cfg_addr == PCIIR_SCI_IRQ_SELECT_OFS) begin // see [R2]
      sci_sel_d = cfg_wdata[2:0] & PCIIR_SCI_WR_MASK[2:0];
    end
    for (int i = 0; i < NUM_LINES; i++) begin
      // Bits 6:4 are masked off so they never hold a value. see [R9]
      if (cfg_wr && cfg_addr == PCIIR_ROUTE_OFS[i]) begin // see [R4] see [R5]
        route_d[i] = cfg_wdata & PCIIR_ROUTE_WR_MASK;
      end
    end
    if (cfg_rd) begin
      // Unmapped offsets answer with zero so a probe never sees stale data.
      rdata_d = 8'h00;
      if (cfg_addr == PCIIR_SCI_IRQ_SELECT_OFS) begin
        rdata_d = {5'h00, sci_sel_q};
      end
      for (int i = 0; i < NUM_LINES; i++) begin
        if (cfg_addr == PCIIR_ROUTE_OFS[i]) begin
          rdata_d = route_q[i];
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sci_sel_q <= PCIIR_SCI_SEL_RESET; // see [R1]
      rdata_q <= 8'h00;
      for (int i = 0; i < NUM_LINES; i++) begin
        route_q[i] <= PCIIR_ROUTE_RESET;
      end
    end else begin
      sci_sel_q <= sci_sel_d;
      rdata_q <= rdata_d;
      for (int i = 0; i < NUM_LINES; i++) begin
        route_q[i] <= route_d[i];
      end
    end
  end

  assign cfg_rdata = rdata_q;

  // ------------------------------------------------------------------
  // PCI line synchroniser
  // ------------------------------------------------------------------
  logic [NUM_LINES-1:0] sync1_q;
  logic [NUM_LINES-1:0] sync2_q;
  logic [NUM_LINES-1:0] line_act;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else begin
      sync1_q <= pci_interrupt_line_n;
      sync2_q <= sync1_q;
    end
  end

  assign line_act = ~sync2_q;

  // ------------------------------------------------------------------
  // Line decoders
  // ------------------------------------------------------------------
  logic [15:0] line_vec [NUM_LINES];

  for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
    pciir_line_decode u_dec (
      .route(route_q[g]),
      .line_act(line_act[g]),
      .irq_vec(line_vec[g])
    );
  end

  // ------------------------------------------------------------------
  // Target merge
  // ------------------------------------------------------------------
  // Lines are level sensitive and shareable, so targets are a plain OR;
  // the registered output costs one cycle but keeps the pins glitch free.
  logic [15:0] isa_d;
  logic [15:0] isa_q;
  logic [3:0] apic_d;
  logic [3:0] apic_q;

  always_comb begin
    isa_d = 16'h0000;
    apic_d = 4'h0;
    for (int i = 0; i < NUM_LINES; i++) begin
      isa_d = isa_d | line_vec[i];
    end
    if (sci_in) begin
      case (pciir_sci_sel_t'(sci_sel_q)) // see [R2]
        PCIIR_SCI_IRQ9: isa_d[9] = 1'b1;
        PCIIR_SCI_IRQ10: isa_d[10] = 1'b1;
        PCIIR_SCI_IRQ11: isa_d[11] = 1'b1;
        PCIIR_SCI_RSVD: isa_d = isa_d;
        default: begin
          // The APIC inputs do not exist while it is off. see [R3]
          if (apic_enable) begin
            apic_d[sci_sel_q[1:0]] = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      isa_q <= 16'h0000;
      apic_q <= 4'h0;
    end else begin
      isa_q <= isa_d;
      apic_q <= apic_d;
    end
  end

  assign isa_irq = isa_q;
  assign apic_irq = apic_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  logic all_off;

  always_comb begin
    all_off = 1'b1;
    for (int i = 0; i < NUM_LINES; i++) begin
      all_off = all_off & route_q[i][PCIIR_ROUTE_DISABLE_BIT];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_sci_reset_default: assert property ($rose(resetn) |-> sci_sel_q == 3'h0) // see [R1]
    else $error("SCI select not IRQ9 after reset");

  a_sci_irq9_path: assert property ((sci_in && sci_sel_q == 3'h0) |=> isa_irq[9]) // see [R1]
    else $error("SCI default did not reach IRQ9");

  a_sci_irq10_path: assert property ((sci_in && sci_sel_q == 3'h1) |=> isa_irq[10] && apic_irq == 4'h0) // see [R2]
    else $error("SCI code 001 did not reach IRQ10 alone");

  a_sci_irq11_path: assert property ((sci_in && sci_sel_q == 3'h2) |=> isa_irq[11] && apic_irq == 4'h0) // see [R2]
    else $error("SCI code 010 did not reach IRQ11 alone");

  a_sci_rsvd_quiet: assert property ((sci_in && sci_sel_q == 3'h3 && all_off) // see [R2]
    |=> isa_irq == 16'h0000 && apic_irq == 4'h0)
    else $error("SCI code 011 drove a target");

  a_sci_select_write: assert property ((cfg_wr && cfg_addr == 8'h44) // see [R2]
    |=> {5'h00, sci_sel_q} == ($past(cfg_wdata) & 8'h07))
    else $error("SCI select write not taken");

  a_sci_select_read: assert property ((cfg_rd && cfg_addr == 8'h44) // see [R2]
    |=> cfg_rdata == {5'h00, $past(sci_sel_q)})
    else $error("SCI select read back wrong");

  a_apic_gated_off: assert property (!apic_enable |=> apic_irq == 4'h0) // see [R3]
    else $error("APIC target driven while APIC disabled");

  a_apic_irq20_path: assert property ((sci_in && apic_enable && sci_sel_q == 3'h4) |=> apic_irq == 4'h1) // see [R3]
    else $error("SCI code 100 did not reach IRQ20");

  a_apic_irq21_path: assert property ((sci_in && apic_enable && sci_sel_q == 3'h5) |=> apic_irq == 4'h2) // see [R3]
    else $error("SCI code 101 did not reach IRQ21");

  a_apic_irq22_path: assert property ((sci_in && apic_enable && sci_sel_q == 3'h6) |=> apic_irq == 4'h4) // see [R3]
    else $error("SCI code 110 did not reach IRQ22");

  a_apic_irq23_path: assert property ((sci_in && apic_enable && sci_sel_q == 3'h7) |=> apic_irq == 4'h8) // see [R3]
    else $error("SCI code 111 did not reach IRQ23");

  a_apic_no_isa: assert property ((sci_in && sci_sel_q[2] && all_off) |=> isa_irq == 16'h0000) // see [R3]
    else $error("SCI APIC code leaked onto the 8259");

  a_apic_needs_sci: assert property (!sci_in |=> apic_irq == 4'h0) // see [R3]
    else $error("APIC target driven without SCI");

  a_route_a_write: assert property ((cfg_wr && cfg_addr == 8'h60) // see [R4]
    |=> route_q[0] == ($past(cfg_wdata) & 8'h8F))
    else $error("Line A routing byte write lost");

  a_route_b_write: assert property ((cfg_wr && cfg_addr == 8'h61) // see [R4]
    |=> route_q[1] == ($past(cfg_wdata) & 8'h8F))
    else $error("Line B routing byte write lost");

  a_route_c_write: assert property ((cfg_wr && cfg_addr == 8'h62) // see [R4]
    |=> route_q[2] == ($past(cfg_wdata) & 8'h8F))
    else $error("Line C routing byte write lost");

  a_route_d_write: assert property ((cfg_wr && cfg_addr == 8'h63) // see [R4]
    |=> route_q[3] == ($past(cfg_wdata) & 8'h8F))
    else $error("Line D routing byte write lost");

  a_route_a_read: assert property ((cfg_rd && cfg_addr == 8'h60) // see [R4]
    |=> cfg_rdata == $past(route_q[0]))
    else $error("Line A routing byte read back wrong");

  a_route_e_write: assert property ((cfg_wr && cfg_addr == 8'h68) // see [R5]
    |=> route_q[4] == ($past(cfg_wdata) & 8'h8F))
    else $error("Line E routing byte write lost");

  a_route_f_write: assert property ((cfg_wr && cfg_addr == 8'h69) // see [R5]
    |=> route_q[5] == ($past(cfg_wdata) & 8'h8F))
    else $error("Line F routing byte write lost");

  a_route_g_write: assert property ((cfg_wr && cfg_addr == 8'h6A) // see [R5]
    |=> route_q[6] == ($past(cfg_wdata) & 8'h8F))
    else $error("Line G routing byte write lost");

  a_route_h_write: assert property ((cfg_wr && cfg_addr == 8'h6B) // see [R5]
    |=> route_q[7] == ($past(cfg_wdata) & 8'h8F))
    else $error("Line H routing byte write lost");

  a_route_h_read: assert property ((cfg_rd && cfg_addr == 8'h6B) // see [R5]
    |=> cfg_rdata == $past(route_q[7]))
    else $error("Line H routing byte read back wrong");

  a_line_a_irq3: assert property ((route_q[0] == 8'h03 && line_act[0]) |=> isa_irq[3]) // see [R6]
    else $error("Line A code 0011 did not reach IRQ3");

  a_line_d_irq3: assert property ((route_q[3] == 8'h03 && line_act[3]) |=> isa_irq[3]) // see [R6]
    else $error("Line D code 0011 did not reach IRQ3");

  a_line_h_irq7: assert property ((route_q[7] == 8'h07 && line_act[7]) |=> isa_irq[7]) // see [R6]
    else $error("Line H code 0111 did not reach IRQ7");

  a_line_b_irq9: assert property ((route_q[1] == 8'h09 && line_act[1]) |=> isa_irq[9]) // see [R6]
    else $error("Line B code 1001 did not reach IRQ9");

  a_line_c_irq10: assert property ((route_q[2] == 8'h0A && line_act[2]) |=> isa_irq[10]) // see [R6]
    else $error("Line C code 1010 did not reach IRQ10");

  a_line_e_irq12: assert property ((route_q[4] == 8'h0C && line_act[4]) |=> isa_irq[12]) // see [R6]
    else $error("Line E code 1100 did not reach IRQ12");

  a_line_g_irq14: assert property ((route_q[6] == 8'h0E && line_act[6]) |=> isa_irq[14]) // see [R6]
    else $error("Line G code 1110 did not reach IRQ14");

  a_line_h_irq15: assert property ((route_q[7] == 8'h0F && line_act[7]) |=> isa_irq[15]) // see [R6]
    else $error("Line H code 1111 did not reach IRQ15");

  a_all_lines_off: assert property ((all_off && !sci_in) |=> isa_irq == 16'h0000) // see [R7]
    else $error("Disabled lines still reach the 8259");

  a_reserved_read_zero: assert property ((cfg_rd && cfg_addr[7:4] == 4'h6) |=> cfg_rdata[6:4] == 3'h0) // see [R9]
    else $error("Reserved routing bits read non-zero");

endmodule

`default_nettype wire

// ===== pciir_pic_model.sv
/*
  Model of the legacy interrupt controller pair and APIC that sit behind the
  routing block. Assumes level requests on the block's clock.
*/
`timescale 1ns/1ps
`default_nettype none

module pciir_pic_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Request levels from the routing block
  input wire logic [15:0] isa_irq,
  input wire logic [3:0] apic_irq,
  // Levels as latched by the controllers
  output logic [19:0] irq_seen
);
  logic [19:0] seen_d;
  logic [19:0] seen_q;

  // Controllers latch levels each edge, so a glitch shorter than one cycle is missed.
  always_comb begin
    seen_d = {apic_irq, isa_irq};
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      seen_q <= 20'h00000;
    end else begin
      seen_q <= seen_d;
    end
  end

  assign irq_seen = seen_q;
endmodule

`default_nettype wire

// ===== pciir_route_tb.sv
/*
  Self-checking bench for the routing block, with random and corner stimulus.
  Assumes the controller model sits on the block's interrupt outputs.
*/
`timescale 1ns/1ps
`default_nettype none

module pciir_route_tb;
  import pciir_pkg::*;
  logic ref_clk, resetn, cfg_wr, cfg_rd, sci_in, apic_enable;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, lines_n, rd, act;
  logic [15:0] isa_irq;
  logic [3:0] apic_irq;
  logic [19:0] irq_seen;
  logic [7:0] rt [8];
  logic [2:0] sel;
  int n_mismatch, cmp_count, cyc;
  int legal [11] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};

  pciir_route #(.NUM_LINES(8)) u_pciir_route (.ref_clk(ref_clk), .resetn(resetn), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .pci_interrupt_line_n(lines_n), .sci_in(sci_in), .apic_enable(apic_enable),
    .isa_irq(isa_irq), .apic_irq(apic_irq));
  pciir_pic_model u_pciir_pic_model (.ref_clk(ref_clk), .resetn(resetn), .isa_irq(isa_irq),
    .apic_irq(apic_irq), .irq_seen(irq_seen));

  always #5 ref_clk = ~ref_clk;

  // --------------------------------------------------------------
  // Expectations
  // --------------------------------------------------------------
  function automatic logic [19:0] exp_out();
    logic [19:0] v;
    v = 20'h00000;
    for (int i = 0; i < 8; i++) begin
      if (act[i] && !rt[i][7] && (rt[i][3:0] inside {[3:7], [9:12], 14, 15})) v[rt[i][3:0]] = 1'b1;
    end
    if (sci_in && sel < 3) v[9 + sel] = 1'b1;
    if (sci_in && sel[2] && apic_enable) v[16 + sel[1:0]] = 1'b1;
    return v;
  endfunction

  // --------------------------------------------------------------
  // Port tasks
  // --------------------------------------------------------------
  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_reg(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_out(input string nm, input logic [19:0] e, input logic [19:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // A spare cycle follows each strobe so it is never dropped and raised in one step.
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(posedge ref_clk) #1;
    cfg_wr = 1'b0;
    @(posedge ref_clk) #1;
  endtask

  task automatic cfg_read(input logic [7:0] a, output logic [7:0] d);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(posedge ref_clk) #1;
    cfg_rd = 1'b0;
    @(posedge ref_clk) #1;
    d = cfg_rdata;
  endtask

  task automatic settle_chk();
    lines_n = ~act;
    repeat (6) @(posedge ref_clk);
    #1;
    chk_out("irq", exp_out(), irq_seen);
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    {ref_clk, resetn, cfg_wr, cfg_rd, sci_in, apic_enable} = 6'h00;
    {cfg_addr, cfg_wdata, act, sel} = 27'h0;
    lines_n = 8'hFF;
    n_mismatch = 0;
    cmp_count = 0;
    cyc = 0;
    foreach (rt[i]) rt[i] = 8'h80;
    void'($urandom(99));
    repeat (5) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    @(posedge ref_clk) #1;
    cfg_read(PCIIR_SCI_IRQ_SELECT_OFS, rd);
    chk_reg("sci_irq_select", 8'h00, rd);
    sci_in = 1'b1;
    settle_chk();
    for (int i = 0; i < 8; i++) begin
      cfg_read(PCIIR_ROUTE_OFS[i], rd);
      chk_reg("route reset", 8'h80, rd);
      cfg_write(PCIIR_ROUTE_OFS[i], 8'hFF);
      cfg_read(PCIIR_ROUTE_OFS[i], rd);
      chk_reg("route mask", 8'h8F, rd);
    end
    cfg_write(PCIIR_SCI_IRQ_SELECT_OFS, 8'hFF);
    cfg_read(PCIIR_SCI_IRQ_SELECT_OFS, rd);
    chk_reg("sci mask", 8'h07, rd);
    cfg_write(8'h64, 8'hFF);
    cfg_read(8'h64, rd);
    chk_reg("unmapped", 8'h00, rd);
    for (int s = 0; s < 16; s++) begin
      sel = s[2:0];
      apic_enable = s[3];
      cfg_write(PCIIR_SCI_IRQ_SELECT_OFS, {5'h00, sel});
      settle_chk();
    end
    sci_in = 1'b0;
    foreach (rt[i]) rt[i] = 8'hFF;
    for (int c = 0; c < 32; c++) begin
      rt[c % 8] = {c[4], 3'h0, c[3:0]};
      act = 8'h01 << (c % 8);
      cfg_write(PCIIR_ROUTE_OFS[c % 8], rt[c % 8]);
      settle_chk();
    end
    rt[0] = 8'h03;
    act = 8'h01;
    cfg_write(PCIIR_ROUTE_OFS[0], rt[0]);
    settle_chk();
    for (int n = 0; n < 30; n++) begin
      for (int i = 0; i < 8; i++) begin
        rt[i] = {1'($urandom % 2), 3'h0, 4'(legal[$urandom % 11])};
        cfg_write(PCIIR_ROUTE_OFS[i], rt[i] | 8'h70);
      end
      cfg_read(PCIIR_ROUTE_OFS[n % 8], rd);
      chk_reg("route rand", rt[n % 8], rd);
      act = 8'($urandom);
      sci_in = 1'($urandom);
      apic_enable = 1'($urandom);
      sel = 3'($urandom);
      cfg_write(PCIIR_SCI_IRQ_SELECT_OFS, {5'h00, sel});
      settle_chk();
    end
    // A second reset mid-run must bring the SCI select and line H routing bytes back to their defaults.
    resetn = 1'b0;
    @(posedge ref_clk) #1;
    resetn = 1'b1;
    @(posedge ref_clk) #1;
    sel = PCIIR_SCI_SEL_RESET;
    foreach (rt[i]) rt[i] = PCIIR_ROUTE_RESET;
    cfg_read(PCIIR_SCI_IRQ_SELECT_OFS, rd);
    chk_reg("sci reset again", {5'h00, PCIIR_SCI_SEL_RESET}, rd);
    cfg_read(PCIIR_ROUTE_OFS[7], rd);
    chk_reg("route reset again", PCIIR_ROUTE_RESET, rd);
    settle_chk();
    print_verdict();
  end
endmodule

`default_nettype wire
